// >>> rtl/exs_sequencer.sv
// exposure sequencer: trigger handling, interval timing, wishbone registers
module exs_sequencer
  import exs_pkg::*;
#(
  parameter logic [36:0] P_LONG_MIN_CYC = LONG_MIN_CYC,
  parameter logic [36:0] P_EXP_MAX_CYC = EXP_MAX_CYC,
  parameter logic [36:0] P_FAST_MAX_CYC = FAST_MAX_CYC,
  parameter logic [36:0] P_PHASE_CYC = PHASE_IN_CYC,
  parameter logic [36:0] P_DEAD_CYC = DEAD_CYC,
  parameter logic [36:0] P_READOUT_CYC = READOUT_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic EXPOSURE_TRIGGER_INPUT,
  output exs_sensor_t SENSOR_CTRL
);
  typedef struct packed {
    exs_state_t st;
    logic [36:0] tmr;
    logic [3:0] idx;
    logic [15:0] rep;
    logic img;
    logic ro_start;
    logic trig_q;
    logic start;
    exs_mode_t mode;
    logic src_ext;
    logic pol_fall;
    logic [3:0] npairs;
    logic [MAX_PAIRS-1:0][31:0] dly;
    logic [MAX_PAIRS-1:0][31:0] expo;
    logic [MAX_BLOCKS-1:0][15:0] cnt;
    logic ack;
    logic [31:0] dat;
  } exs_core_t;

  exs_core_t s_ff;
  exs_core_t nxt_s;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;
  logic trig_act;
  logic evt;
  logic wr;
  logic [31:0] rd_mux;
  logic [3:0] last_pair;

  // release reset through two flops so every flop leaves reset together
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // duration word: bit 31 selects microseconds, otherwise clock cycles
  function automatic logic [36:0] dur_cyc(input logic [31:0] raw,
                                          input exs_mode_t md);
    logic [36:0] c;
    logic [36:0] lo;
    logic [36:0] hi;
    c = raw[DUR_UNIT_US] ? 37'(raw[30:0]) * 37'(CYC_PER_US)
                         : 37'(raw[30:0]);
    lo = P_LONG_MIN_CYC;
    hi = P_EXP_MAX_CYC;
    case (md)
      M_LONG:
      begin
        lo = P_LONG_MIN_CYC;
        hi = P_EXP_MAX_CYC;
      end
      M_HS_STD:
      begin
        lo = HS_MIN_CYC;
        hi = P_EXP_MAX_CYC;
      end
      M_FAST_STD, M_FAST_CYC:
      begin
        lo = FAST_MIN_CYC;
        hi = P_FAST_MAX_CYC;
      end
      default:
      begin
        lo = 37'h0000000001;
        hi = P_EXP_MAX_CYC;
      end
    endcase
    if (c < lo)
      c = lo;
    if (c > hi)
      c = hi;
    return c - 37'h0000000001;
  endfunction

  // a zero delay still takes one cycle; only exposures are clamped to the mode range
  function automatic logic [36:0] dly_cyc(input logic [31:0] raw);
    logic [36:0] c;
    c = raw[DUR_UNIT_US] ? 37'(raw[30:0]) * 37'(CYC_PER_US)
                         : 37'(raw[30:0]);
    if (c == 37'h0000000000)
      c = 37'h0000000001;
    return c - 37'h0000000001;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  assign last_pair = (s_ff.npairs == 4'h0) ? 4'h0 :
                     (s_ff.npairs > 4'(MAX_PAIRS)) ? 4'(MAX_PAIRS - 1) :
                     s_ff.npairs - 4'h1;

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (WB_ADR_I[7:6])
      GRP_CTRL:
        case (WB_ADR_I[5:2])
          IDX_CTRL:
            rd_mux = {23'h000000, s_ff.start, 3'h0, s_ff.pol_fall,
                      s_ff.src_ext, s_ff.mode};
          IDX_STATUS:
            rd_mux = {20'h00000, s_ff.idx, s_ff.st[8:1]};
          IDX_NPAIRS:
            rd_mux = {28'h0000000, s_ff.npairs};
          default:
            rd_mux = 32'h00000000;
        endcase
      GRP_DELAY:
        if (WB_ADR_I[5:2] < 4'(MAX_PAIRS))
          rd_mux = s_ff.dly[WB_ADR_I[5:2]];
      GRP_EXPO:
        if (WB_ADR_I[5:2] < 4'(MAX_PAIRS))
          rd_mux = s_ff.expo[WB_ADR_I[5:2]];
      default:
        if (WB_ADR_I[5:2] < 4'(MAX_BLOCKS))
          rd_mux = {16'h0000, s_ff.cnt[WB_ADR_I[5:2]]};
    endcase
  end

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.ro_start = 1'b0;
    nxt_s.trig_q = EXPOSURE_TRIGGER_INPUT;
    trig_act = EXPOSURE_TRIGGER_INPUT ^ s_ff.pol_fall;
    // only a fresh edge or a software start counts as an event
    evt = s_ff.src_ext ? (trig_act & ~(s_ff.trig_q ^ s_ff.pol_fall))
                       : s_ff.start;
    if (s_ff.tmr != 37'h0000000000)
      nxt_s.tmr = s_ff.tmr - 37'h0000000001;
    case (s_ff.st)
      S_IDLE:
        if (evt)
        begin
          nxt_s.start = 1'b0;
          nxt_s.idx = 4'h0;
          nxt_s.rep = 16'h0001;
          nxt_s.img = 1'b0;
          if (s_ff.mode == M_DOUBLE || s_ff.mode == M_HS_DOUBLE)
          begin
            // software start has no pulse width, so double needs the pin
            if (s_ff.src_ext)
              nxt_s.st = S_DEXP;
          end
          else
          begin
            nxt_s.st = S_PHASE;
            nxt_s.tmr = P_PHASE_CYC - 37'h0000000001;
          end
        end
      S_PHASE:
        if (s_ff.tmr == 37'h0000000000)
        begin
          nxt_s.st = S_DELAY;
          nxt_s.tmr = dly_cyc(s_ff.dly[s_ff.idx]);
        end
      S_DELAY:
        if (s_ff.tmr == 37'h0000000000)
        begin
          nxt_s.st = S_EXPOSE;
          nxt_s.tmr = dur_cyc(s_ff.expo[s_ff.idx], s_ff.mode);
        end
      S_EXPOSE:
        if (s_ff.tmr == 37'h0000000000)
        begin
          if (s_ff.mode == M_FAST_CYC)
          begin
            if (s_ff.rep < s_ff.cnt[s_ff.idx[2:0]])
            begin
              nxt_s.rep = s_ff.rep + 16'h0001;
              nxt_s.st = S_WAIT;
            end
            else if (s_ff.idx < 4'(MAX_BLOCKS - 1))
            begin
              nxt_s.idx = s_ff.idx + 4'h1;
              nxt_s.rep = 16'h0001;
              nxt_s.st = S_WAIT;
            end
            else
            begin
              nxt_s.st = S_READ;
              nxt_s.ro_start = 1'b1;
              nxt_s.tmr = P_READOUT_CYC - 37'h0000000001;
            end
          end
          else if (s_ff.mode == M_FAST_STD && s_ff.idx < last_pair)
          begin
            nxt_s.st = S_DEAD;
            nxt_s.tmr = P_DEAD_CYC - 37'h0000000001;
          end
          else
          begin
            nxt_s.st = S_READ;
            nxt_s.ro_start = 1'b1;
            nxt_s.tmr = P_READOUT_CYC - 37'h0000000001;
          end
        end
      S_DEAD:
        if (s_ff.tmr == 37'h0000000000)
        begin
          nxt_s.idx = s_ff.idx + 4'h1;
          nxt_s.st = S_DELAY;
          nxt_s.tmr = dly_cyc(s_ff.dly[s_ff.idx + 4'h1]);
        end
      S_WAIT:
        if (evt)
        begin
          nxt_s.start = 1'b0;
          nxt_s.st = S_DELAY;
          nxt_s.tmr = dly_cyc(s_ff.dly[s_ff.idx]);
        end
      S_DEXP:
        if (!trig_act)
        begin
          nxt_s.st = S_GAP;
          nxt_s.tmr = (s_ff.mode == M_HS_DOUBLE) ? HS_GAP_CYC - 37'h1
                                                  : DBL_GAP_CYC - 37'h1;
        end
      S_GAP:
        if (s_ff.tmr == 37'h0000000000)
        begin
          nxt_s.st = S_READ;
          nxt_s.ro_start = 1'b1;
          nxt_s.tmr = P_READOUT_CYC - 37'h0000000001;
        end
      S_READ:
        if (s_ff.tmr == 37'h0000000000)
        begin
          if ((s_ff.mode == M_DOUBLE || s_ff.mode == M_HS_DOUBLE) &&
              !s_ff.img)
          begin
            nxt_s.img = 1'b1;
            nxt_s.ro_start = 1'b1;
            nxt_s.tmr = P_READOUT_CYC - 37'h0000000001;
          end
          else
            nxt_s.st = S_IDLE;
        end
      default:
        nxt_s.st = S_IDLE;
    endcase
    // bus: ack one cycle after the request, write lands on the ack edge
    nxt_s.ack = WB_CYC_I & WB_STB_I & ~s_ff.ack;
    if (WB_CYC_I & WB_STB_I & ~s_ff.ack)
      nxt_s.dat = rd_mux;
    wr = WB_CYC_I & WB_STB_I & WB_WE_I & s_ff.ack;
    if (wr)
      case (WB_ADR_I[7:6])
        GRP_CTRL:
          if (WB_ADR_I[5:2] == IDX_CTRL)
          begin
            if (WB_SEL_I[0])
            begin
              nxt_s.mode = exs_mode_t'(WB_DAT_I[2:0]);
              nxt_s.src_ext = WB_DAT_I[CTRL_SRC_EXT];
              nxt_s.pol_fall = WB_DAT_I[CTRL_FALLING];
            end
            // a start written while one is consumed survives
            if (WB_SEL_I[1] && WB_DAT_I[CTRL_START])
              nxt_s.start = 1'b1;
          end
          else if (WB_ADR_I[5:2] == IDX_NPAIRS && WB_SEL_I[0])
            nxt_s.npairs = WB_DAT_I[3:0];
        GRP_DELAY:
          if (WB_ADR_I[5:2] < 4'(MAX_PAIRS))
            nxt_s.dly[WB_ADR_I[5:2]] =
              merge(s_ff.dly[WB_ADR_I[5:2]], WB_DAT_I, WB_SEL_I);
        GRP_EXPO:
          if (WB_ADR_I[5:2] < 4'(MAX_PAIRS))
            nxt_s.expo[WB_ADR_I[5:2]] =
              merge(s_ff.expo[WB_ADR_I[5:2]], WB_DAT_I, WB_SEL_I);
        default:
          if (WB_ADR_I[5:2] < 4'(MAX_BLOCKS))
            nxt_s.cnt[WB_ADR_I[5:2]] = 16'(merge(
              {16'h0000, s_ff.cnt[WB_ADR_I[5:2]]}, WB_DAT_I, WB_SEL_I));
      endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_ff <= '0;
      s_ff.st <= S_IDLE;
      s_ff.mode <= M_LONG;
      s_ff.npairs <= NPAIRS_RST;
    end
    else
      s_ff <= nxt_s;
  end

  assign WB_ACK_O = s_ff.ack;
  assign WB_DAT_O = s_ff.dat;
  // one driver for the whole struct; fields in packed order, msb first
  // second double-shutter image integrates during the first readout
  assign SENSOR_CTRL = {
    (s_ff.st == S_EXPOSE) || (s_ff.st == S_DEXP) ||
      ((s_ff.st == S_READ) && !s_ff.img &&
      (s_ff.mode == M_DOUBLE || s_ff.mode == M_HS_DOUBLE)),
    (s_ff.st == S_READ),
    s_ff.ro_start,
    s_ff.img,
    (s_ff.st != S_IDLE)};

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!rst_n);

  sequence seq_gap8;
    (s_ff.st == S_GAP) [*8] ##1 (s_ff.st == S_READ);
  endsequence
  sequence seq_gap20;
    (s_ff.st == S_GAP) [*8] ##12 (s_ff.st == S_GAP) ##1 (s_ff.st == S_READ);
  endsequence

  a_idle_needs_event: assert property ((s_ff.st == S_IDLE) && !evt |=>
    (s_ff.st == S_IDLE)) else $error("sequence left idle without trigger");
  a_phase_first: assert property ((s_ff.st == S_IDLE) && evt &&
    s_ff.mode != M_DOUBLE && s_ff.mode != M_HS_DOUBLE |=>
    (s_ff.st == S_PHASE)) else $error("phase-in missing after trigger");
  a_delay_then_expose: assert property ((s_ff.st == S_DELAY) &&
    s_ff.tmr == 37'h0 |=> (s_ff.st == S_EXPOSE))
    else $error("exposure did not follow delay");
  a_pair_limit: assert property (s_ff.idx < 4'(MAX_PAIRS))
    else $error("pair index beyond ten");
  a_fast_min_exp: assert property ($rose(s_ff.st == S_EXPOSE) &&
    s_ff.mode == M_FAST_STD |-> (s_ff.st == S_EXPOSE) [*4])
    else $error("fast exposure shorter than minimum");
  a_long_min_exp: assert property ($rose(s_ff.st == S_EXPOSE) &&
    (s_ff.mode == M_LONG || s_ff.mode == M_HS_STD) |->
    (s_ff.st == S_EXPOSE) [*8]) else $error("exposure below minimum");
  a_readout_follows: assert property ((s_ff.st == S_EXPOSE) &&
    s_ff.tmr == 37'h0 && s_ff.mode == M_FAST_STD && s_ff.idx == last_pair
    |=> (s_ff.st == S_READ) && s_ff.ro_start)
    else $error("readout did not start after last exposure");
  a_cycle_readout: assert property ($rose(s_ff.st == S_READ) &&
    s_ff.mode == M_FAST_CYC |-> s_ff.idx == 4'(MAX_BLOCKS - 1))
    else $error("cycled readout before fifth block");
  a_cycle_waits: assert property ((s_ff.st == S_WAIT) && !evt |=>
    (s_ff.st == S_WAIT)) else $error("cycled exposure ran without trigger");
  a_dbl_gap: assert property ($rose(s_ff.st == S_GAP) &&
    s_ff.mode == M_DOUBLE |-> seq_gap8) else $error("double gap not 200ns");
  a_hs_gap: assert property ($rose(s_ff.st == S_GAP) &&
    s_ff.mode == M_HS_DOUBLE |-> seq_gap20)
    else $error("high-sensitivity gap not 500ns");
  a_dbl_follows_pin: assert property ((s_ff.st == S_DEXP) && trig_act
    |=> (s_ff.st == S_DEXP) && SENSOR_CTRL.integrate)
    else $error("first integration ended while trigger active");
  a_second_int: assert property ($rose(s_ff.img) &&
    (s_ff.st == S_READ) |-> $past(SENSOR_CTRL.integrate) &&
    !SENSOR_CTRL.integrate) else $error("second integration not readout");
endmodule

// >>> shared/exs_pkg.sv
// package of constants and types for the exposure sequencer
// Behaviour
// - long exposure mode accepts exposure durations from 1ms to 1000s.
// - a sequence starts only on an internal or external trigger event.
// - high-sensitivity standard mode accepts durations from 500ns to 1000s.
// - fast shutter offers standard and cycled-block modes, chosen by config.
// - fast standard mode times exposures from 100ns to 1ms each.
// - standard multiple exposure uses at most 10 delay/exposure pairs.
// - one trigger pulse starts a whole multiple exposure.
// - readout of the 12-bit image starts right after the last exposure.
// - cycled-block mode holds five blocks: delay, exposure, repeat count.
// - cycled blocks accumulate one image; readout only after block five.
// - in cycled-block mode each exposure waits for its own trigger.
// - double shutter takes two images at least 200ns apart.
// - first double-shutter integration follows the trigger pulse width.
// - second integration lasts exactly as long as the first readout.
// - high-sensitivity double shutter uses a 500ns gap, 3us-10ms pulse; the code does not check the pulse width.
// - phase-in, intrinsic dead time and readout are inserted intervals.
package exs_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam longint CLK_HZ = 40000000;
  localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
  localparam longint LONG_MIN_MS = 1;
  localparam longint EXP_MAX_S = 1000;
  localparam int HS_MIN_NS = 500;
  localparam int FAST_MIN_NS = 100;
  localparam longint FAST_MAX_MS = 1;
  localparam int DBL_GAP_NS = 200;
  localparam int HS_GAP_NS = 500;
  localparam logic [36:0] LONG_MIN_CYC = 37'(LONG_MIN_MS * CLK_HZ / 1000);
  localparam logic [36:0] EXP_MAX_CYC = 37'(EXP_MAX_S * CLK_HZ);
  localparam logic [36:0] HS_MIN_CYC =
    37'((HS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [36:0] FAST_MIN_CYC =
    37'((FAST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [36:0] FAST_MAX_CYC = 37'(FAST_MAX_MS * CLK_HZ / 1000);
  localparam logic [36:0] DBL_GAP_CYC =
    37'((DBL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [36:0] HS_GAP_CYC =
    37'((HS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [36:0] PHASE_IN_CYC = 37'h0000000028;
  localparam logic [36:0] DEAD_CYC = 37'h0000000010;
  localparam logic [36:0] READOUT_CYC = 37'h0000000FA0;
  localparam int MAX_PAIRS = 10;
  localparam int MAX_BLOCKS = 5;
  localparam logic [1:0] GRP_CTRL = 2'h0;
  localparam logic [1:0] GRP_DELAY = 2'h1;
  localparam logic [1:0] GRP_EXPO = 2'h2;
  localparam logic [1:0] GRP_COUNT = 2'h3;
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_NPAIRS = 4'h2;
  localparam logic [3:0] NPAIRS_RST = 4'h1;
  localparam int CTRL_SRC_EXT = 3;
  localparam int CTRL_FALLING = 4;
  localparam int CTRL_START = 8;
  localparam int DUR_UNIT_US = 31;
  typedef enum logic [2:0] {
    M_LONG = 3'h0, M_HS_STD = 3'h1, M_FAST_STD = 3'h2,
    M_FAST_CYC = 3'h3, M_DOUBLE = 3'h4, M_HS_DOUBLE = 3'h5
  } exs_mode_t;
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_PHASE = 9'h002, S_DELAY = 9'h004,
    S_EXPOSE = 9'h008, S_DEAD = 9'h010, S_WAIT = 9'h020,
    S_DEXP = 9'h040, S_GAP = 9'h080, S_READ = 9'h100
  } exs_state_t;
  typedef struct packed {
    logic integrate;
    logic readout;
    logic readout_start;
    logic image_sel;
    logic busy;
  } exs_sensor_t;
endpackage

// >>> verification/exposure_sequencer_tb.sv
// self-checking bench for the exposure sequencer
module exposure_sequencer_tb
  import exs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LMIN = 8;
  localparam int EMAX = 1000;
  localparam int FMAX = 200;
  localparam int PH = 4;
  localparam int DD = 4;
  localparam int RD = 32;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic fire = 1'b0;
  logic trig;
  logic ack;
  logic int_q = 1'b0;
  logic inv = 1'b0;
  logic flash;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat_o;
  logic [31:0] rd_v;
  logic [15:0] width = 16'h2;
  exs_sensor_t sc;
  int failures = 0;
  int n_tests = 0;
  int n_int, n_rise, n_rs, n_rd, n_both, n_gap, n_sel, n_flash;

  exs_sequencer #(.P_LONG_MIN_CYC(37'(LMIN)), .P_EXP_MAX_CYC(37'(EMAX)),
    .P_FAST_MAX_CYC(37'(FMAX)), .P_PHASE_CYC(37'(PH)),
    .P_DEAD_CYC(37'(DD)), .P_READOUT_CYC(37'(RD))) exs_sequencer_i (
    .SYS_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat_o), .WB_ACK_O(ack), .EXPOSURE_TRIGGER_INPUT(trig ^ inv),
    .SENSOR_CTRL(sc));
  exs_host_model exs_host_model_i (.clk(clk), .rst_n(rst_n), .fire(fire),
    .width(width), .trig(trig), .flash(flash));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // counts outputs every cycle; cleared on a falling edge to avoid races
  always @(posedge clk)
  begin
    int_q <= sc.integrate;
    if (sc.integrate === 1'b1) n_int++;
    if (sc.integrate === 1'b1 && int_q !== 1'b1) n_rise++;
    if (sc.readout_start === 1'b1) n_rs++;
    if (sc.readout === 1'b1) n_rd++;
    if (sc.integrate === 1'b1 && sc.readout === 1'b1) n_both++;
    if (sc.busy === 1'b1 && sc.integrate !== 1'b1 && sc.readout !== 1'b1)
      n_gap++;
    if (sc.image_sel === 1'b1 && sc.readout === 1'b1) n_sel++;
    if (flash === 1'b1 && sc.integrate === 1'b1 && sc.readout === 1'b1)
      n_flash++;
  end

  task automatic conclude;
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] seen,
    input logic [39:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // one classic cycle; ack is sampled at the edge, the bench timeout ends hangs
  task automatic wb_cycle(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    rd_v = rdat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d, 4'hF);
  endtask

  task automatic clr;
    @(negedge clk);
    {n_int, n_rise, n_rs, n_rd, n_both, n_gap, n_sel, n_flash} = '0;
  endtask

  task automatic pulse(input logic [15:0] w);
    @(posedge clk);
    width <= w;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic wait_idle;
    repeat (3) @(posedge clk);
    while (sc.busy !== 1'b0) @(posedge clk);
  endtask

  task automatic t_regs;
    chk("busy", sc.busy, 1'b0);
    wb_cycle(1'b0, 8'h00, 32'h0, 4'hF);
    chk("ctrl", rd_v, 40'h0);
    wb_cycle(1'b1, 8'h08, 32'h5, 4'h0);
    wb_cycle(1'b0, 8'h08, 32'h0, 4'hF);
    chk("npairs", rd_v, 40'h1);
    wr(8'h3C, 32'hFFFFFFFF);
    wb_cycle(1'b0, 8'h3C, 32'h0, 4'hF);
    chk("unmapped", rd_v, 40'h0);
  endtask

  task automatic t_fast2;
    wr(8'h00, 32'h0A);
    wr(8'h08, 32'h2);
    wr(8'h40, 32'h3);
    wr(8'h80, 32'h5);
    wr(8'h44, 32'h6);
    wr(8'h84, 32'h7);
    clr;
    pulse(16'h2);
    repeat (10) @(posedge clk);
    pulse(16'h2);
    wait_idle;
    chk("fast2 rises", n_rise, 40'h2);
    chk("fast2 integ", n_int, 40'd12);
    chk("fast2 gap", n_gap, 40'(PH + 3 + DD + 6));
    chk("fast2 reads", n_rs, 40'h1);
    chk("fast2 rdlen", n_rd, 40'(RD));
  endtask

  // low-active trigger: the pin idles high and a low pulse starts a run
  task automatic t_fall;
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1A);
    @(posedge clk);
    inv <= 1'b1;
    repeat (4) @(posedge clk);
    chk("fall idle", sc.busy, 1'b0);
    clr;
    pulse(16'h2);
    wait_idle;
    chk("fall rises", n_rise, 40'h1);
    chk("fall integ", n_int, 40'h5);
    chk("fall reads", n_rs, 40'h1);
    // leave external source first, so restoring the pin makes no event
    wr(8'h00, 32'h02);
    @(posedge clk);
    inv <= 1'b0;
    repeat (4) @(posedge clk);
    chk("fall restore", sc.busy, 1'b0);
  endtask

  task automatic t_clamp;
    int md[5] = '{0, 0, 1, 2, 2};
    int ex[5] = '{2, 1500, 10, 1, 300};
    int ev[5];
    ev = '{LMIN, EMAX, int'(HS_MIN_CYC), int'(FAST_MIN_CYC), FMAX};
    wr(8'h08, 32'h1);
    wr(8'h40, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h80, 32'(ex[i]));
      clr;
      wr(8'h00, 32'(md[i]) | 32'h100);
      wait_idle;
      chk("clamp", n_int, 40'(ev[i]));
      chk("clamp reads", n_rs, 40'h1);
      wb_cycle(1'b0, 8'h00, 32'h0, 4'hF);
      chk("start clear", rd_v, 40'(md[i]));
    end
  endtask

  task automatic t_ten;
    wr(8'h08, 32'hF);
    for (int i = 0; i < 10; i++)
    begin
      wr(8'(8'h40 + 4 * i), 32'h1);
      wr(8'(8'h80 + 4 * i), 32'h4);
    end
    clr;
    wr(8'h00, 32'h102);
    wait_idle;
    chk("ten rises", n_rise, 40'd10);
    chk("ten integ", n_int, 40'd40);
    chk("ten gap", n_gap, 40'(PH + 10 + 9 * DD));
  endtask

  task automatic t_cycled;
    wr(8'h00, 32'h0B);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'(8'h40 + 4 * i), 32'h2);
      wr(8'(8'h80 + 4 * i), 32'h3);
      wr(8'(8'hC0 + 4 * i), (i == 0) ? 32'h2 : 32'h0);
    end
    clr;
    for (int k = 0; k < 6; k++)
    begin
      pulse(16'h2);
      repeat (16) @(posedge clk);
      if (k == 4) chk("cyc early", n_rs, 40'h0);
      if (k == 4) chk("cyc busy", sc.busy, 1'b1);
    end
    wait_idle;
    chk("cyc rises", n_rise, 40'h6);
    chk("cyc integ", n_int, 40'(6 * FAST_MIN_CYC));
    chk("cyc reads", n_rs, 40'h1);
  endtask

  task automatic t_double;
    for (int m = 4; m < 6; m++)
    begin
      wr(8'h00, 32'(m) | 32'h8);
      clr;
      pulse(16'd20);
      wait_idle;
      chk("dbl reads", n_rs, 40'h2);
      chk("dbl second", n_both, 40'(RD));
      chk("dbl sel", n_sel, 40'(RD));
      chk("dbl gap", n_gap, (m == 5) ? HS_GAP_CYC : DBL_GAP_CYC);
      chk("dbl first", (n_int - n_both) inside {[19:21]}, 1'b1);
      chk("dbl flash", n_flash, 40'h1);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_fast2;
    t_fall;
    t_clamp;
    t_ten;
    t_cycled;
    t_double;
    conclude;
  end

  initial
  begin
    #(25 * 20000);
    failures++;
    conclude;
  end
endmodule

// >>> verification/exs_host_model.sv
// host board model: sends one trigger pulse of a given width per request
module exs_host_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [15:0] width,
  output logic trig,
  output logic flash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left_ff;
  logic trig_q_ff;
  logic [5:0] wait_ff;

  // pulsed source: one short flash well after the trigger ends, so light
  // reaches the second image for less than a whole readout
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_q_ff <= 1'b0;
      wait_ff <= 6'h0;
      flash <= 1'b0;
    end
    else
    begin
      trig_q_ff <= trig;
      flash <= (wait_ff == 6'h1);
      if (trig_q_ff && !trig)
        wait_ff <= 6'd30;
      else if (wait_ff != 6'h0)
        wait_ff <= wait_ff - 6'h1;
    end
  end
  // idle level low, as the pull-down holds it for a rising-active input
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig <= 1'b0;
      left_ff <= 16'h0;
    end
    else if (fire && left_ff == 16'h0)
    begin
      trig <= 1'b1; // one pulse per request
      left_ff <= width; // width sets first integration
    end
    else if (left_ff > 16'h1)
      left_ff <= left_ff - 16'h1;
    else
    begin
      trig <= 1'b0;
      left_ff <= 16'h0;
    end
  end
endmodule
